// *** verilog/pidan_regs.sv ***
// Identifier low word and auto-negotiation advertisement register bank.
// Assumes a synchronous management port: one-cycle read and write
// strobes, read data one cycle later; negotiation engine outside.
`default_nettype none

module pidan_regs #(
    // Arbitrary values, not those of any real part
    parameter logic [5:0] ORG_ID_LOW_BITS = 6'h2a,
    parameter logic [5:0] MODEL_NUMBER = 6'h15,
    parameter logic [3:0] REVISION_NUMBER = 4'h3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr_en,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_rd_en,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rd_valid,
    input wire logic [3:0] strap_abilities,
    input wire logic restart_negotiation,
    input wire logic negotiation_done,
    input wire pidan_pkg::pidan_pause_s partner_pause,
    output logic [15:0] base_page_word,
    output logic negotiation_complete,
    output logic [1:0] pause_resolution
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] adv_view(input logic [15:0] stored);
        adv_view = stored & pidan_pkg::ADV_WRITE_MASK;
    endfunction : adv_view

    function automatic logic [15:0] id_word();
        id_word = {ORG_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER};
    endfunction : id_word

    pidan_pkg::pidan_state_s st;
    pidan_pkg::pidan_state_s next_st;
    pidan_pkg::pidan_pause_s local_pause;
    logic rx_pause_en;
    logic tx_pause_en;
    logic start_now;

    assign local_pause.pause = st.adv[pidan_pkg::ADV_SYM_PAUSE];
    assign local_pause.asym = st.adv[pidan_pkg::ADV_ASYM_PAUSE];

    pidan_pause_res u_pause_res (
        .local_ability(local_pause),
        .partner_ability(partner_pause),
        .rx_pause_en(rx_pause_en),
        .tx_pause_en(tx_pause_en)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        start_now = restart_negotiation || st.start_pending;
        next_st.start_pending = 1'b0;
        next_st.rd_valid = mgmt_rd_en;
        // Straps caught once, first cycle after release
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.start_pending = 1'b1;
            next_st.adv[pidan_pkg::ADV_ABILITY_LSB +: 4] = strap_abilities;
        end else if (mgmt_wr_en && mgmt_addr == pidan_pkg::ADDR_ADV) begin
            // Bits 14, 12 and 9 never stored
            next_st.adv = adv_view(mgmt_wdata);
        end
        if (mgmt_rd_en) begin
            case (mgmt_addr)
                pidan_pkg::ADDR_ID_LOW: next_st.rdata = id_word();
                pidan_pkg::ADDR_ADV: next_st.rdata = adv_view(st.adv);
                default: next_st.rdata = pidan_pkg::WORD_RESET;
            endcase
        end
        // Latest advertisement becomes the outgoing base page
        if (start_now) begin
            next_st.base_page = adv_view(st.adv);
            next_st.complete = 1'b0;
        end
        // Completion wins over a coinciding restart
        if (negotiation_done) begin
            next_st.complete = 1'b1;
        end
        next_st.pause_res = st.complete ? {rx_pause_en, tx_pause_en}
                                        : pidan_pkg::PAUSE_RES_RESET;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.adv <= pidan_pkg::ADV_RESET;
            st.rdata <= pidan_pkg::WORD_RESET;
            st.rd_valid <= 1'b0;
            st.strap_done <= 1'b0;
            st.start_pending <= 1'b0;
            st.complete <= 1'b0;
            st.base_page <= pidan_pkg::WORD_RESET;
            st.pause_res <= pidan_pkg::PAUSE_RES_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign mgmt_rdata = st.rdata;
    assign mgmt_rd_valid = st.rd_valid;
    assign base_page_word = st.base_page;
    assign negotiation_complete = st.complete;
    assign pause_resolution = st.pause_res;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic rd_id;
    logic rd_adv;
    logic wr_adv;
    assign rd_id = mgmt_rd_en && mgmt_addr == pidan_pkg::ADDR_ID_LOW;
    assign rd_adv = mgmt_rd_en && mgmt_addr == pidan_pkg::ADDR_ADV;
    assign wr_adv = mgmt_wr_en && mgmt_addr == pidan_pkg::ADDR_ADV && st.strap_done;

    a_oui_low_bits: assert property (rd_id |=> mgmt_rd_valid &&
        mgmt_rdata[15:10] == ORG_ID_LOW_BITS)
        else $error("identifier low bits wrong");
    a_model_field: assert property (rd_id |=> mgmt_rdata[9:4] == MODEL_NUMBER)
        else $error("model number wrong");
    a_revision_field: assert property (rd_id |=>
        mgmt_rdata[3:0] == REVISION_NUMBER)
        else $error("revision number wrong");
    a_next_page_rw: assert property (wr_adv ##1 !mgmt_wr_en ##1 rd_adv |=>
        mgmt_rdata[15] == $past(mgmt_wdata[15], 3))
        else $error("next page bit not stored");
    a_bit14_zero: assert property (rd_adv |=> !mgmt_rdata[14])
        else $error("bit 14 not zero");
    a_remote_fault_rw: assert property (wr_adv |=>
        st.adv[13] == $past(mgmt_wdata[13]))
        else $error("remote fault bit not stored");
    a_bit12_zero: assert property (rd_adv |=> !mgmt_rdata[12])
        else $error("bit 12 not zero");
    a_pause_bits_rw: assert property (wr_adv |=>
        st.adv[11:10] == $past(mgmt_wdata[11:10]))
        else $error("pause bits not stored");
    a_pause_both: assert property (st.complete && local_pause.pause &&
        partner_pause.pause |=> pause_resolution == 2'h3)
        else $error("symmetric pause not resolved");
    a_pause_idle: assert property (!st.complete |=> pause_resolution == 2'h0)
        else $error("pause result before completion");
    a_bit9_zero: assert property (rd_adv |=> !mgmt_rdata[9])
        else $error("four-pair bit not zero");
    a_strap_load: assert property ($rose(st.strap_done) |->
        st.adv[8:5] == $past(strap_abilities) && st.adv[4:0] == 5'h01)
        else $error("strap or selector reset wrong");
    a_selector_rw: assert property (wr_adv |=>
        st.adv[4:0] == $past(mgmt_wdata[4:0]))
        else $error("selector not stored");
    a_base_sample: assert property (restart_negotiation |=>
        base_page_word == adv_view($past(st.adv)))
        else $error("base page not sampled");
    a_done_sets: assert property (negotiation_done |=> negotiation_complete)
        else $error("completion flag not set");
    a_restart_clears: assert property (restart_negotiation &&
        !negotiation_done |=> !negotiation_complete)
        else $error("completion flag not cleared");

    // ****************************************************************
    // Management port checks
    // ****************************************************************
    a_rd_valid_pulse: assert property (mgmt_rd_en |=> mgmt_rd_valid)
        else $error("read valid missing after read");
    a_rd_valid_idle: assert property (!mgmt_rd_en |=> !mgmt_rd_valid)
        else $error("read valid without read");
    a_rdata_holds: assert property (!mgmt_rd_en |=> $stable(mgmt_rdata))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (mgmt_rd_en && !rd_id && !rd_adv |=>
        mgmt_rdata == pidan_pkg::WORD_RESET)
        else $error("unmapped read not zero");
    a_id_word_whole: assert property (rd_id |=>
        mgmt_rdata == {ORG_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER})
        else $error("identifier word wrong");
    a_id_write_ignored: assert property (st.strap_done && mgmt_wr_en &&
        mgmt_addr == pidan_pkg::ADDR_ID_LOW |=> $stable(st.adv))
        else $error("identifier write altered state");

    // ****************************************************************
    // Advertisement storage checks
    // ****************************************************************
    a_adv_reset_bits: assert property ($rose(st.strap_done) |->
        st.adv[15:9] == 7'h00)
        else $error("advertisement reset value wrong");
    a_adv_holds: assert property (st.strap_done && !wr_adv |=>
        $stable(st.adv))
        else $error("advertisement changed without write");
    a_next_page_store: assert property (wr_adv |=>
        st.adv[15] == $past(mgmt_wdata[15]))
        else $error("next page bit not stored");
    a_bit14_ignored: assert property (wr_adv && mgmt_wdata[14] |=>
        !st.adv[14])
        else $error("bit 14 write not ignored");
    a_bit9_ignored: assert property (wr_adv && mgmt_wdata[9] |=>
        !st.adv[9])
        else $error("four-pair write not ignored");
    a_ability_rw: assert property (wr_adv |=>
        st.adv[8:5] == $past(mgmt_wdata[8:5]))
        else $error("ability bits not stored");
    a_fault_readback: assert property (wr_adv ##1 !mgmt_wr_en ##1 rd_adv |=>
        mgmt_rdata[13] == $past(mgmt_wdata[13], 3))
        else $error("remote fault readback wrong");
    a_pause_readback: assert property (wr_adv ##1 !mgmt_wr_en ##1 rd_adv |=>
        mgmt_rdata[11:10] == $past(mgmt_wdata[11:10], 3))
        else $error("pause readback wrong");
    a_ability_readback: assert property (wr_adv ##1 !mgmt_wr_en ##1 rd_adv |=>
        mgmt_rdata[8:5] == $past(mgmt_wdata[8:5], 3))
        else $error("ability readback wrong");
    a_selector_readback: assert property (wr_adv ##1 !mgmt_wr_en ##1 rd_adv |=>
        mgmt_rdata[4:0] == $past(mgmt_wdata[4:0], 3))
        else $error("selector readback wrong");

    // ****************************************************************
    // Negotiation checks
    // ****************************************************************
    a_auto_start: assert property ($rose(st.strap_done) |=>
        base_page_word == adv_view($past(st.adv)))
        else $error("automatic start missed");
    a_base_holds: assert property (!start_now |=>
        $stable(base_page_word))
        else $error("base page changed without start");
    a_complete_holds: assert property (!start_now && !negotiation_done |=>
        $stable(negotiation_complete))
        else $error("completion flag changed on its own");
    a_pause_after_restart: assert property (restart_negotiation &&
        !negotiation_done |=> ##1 pause_resolution == 2'h0)
        else $error("pause result kept after restart");

    // ****************************************************************
    // Pause resolution checks
    // ****************************************************************
    a_pause_rx_only: assert property (st.complete && local_pause.pause &&
        local_pause.asym && !partner_pause.pause && partner_pause.asym |=>
        pause_resolution == 2'h2)
        else $error("receive-only pause not resolved");
    a_pause_tx_only: assert property (st.complete && !local_pause.pause &&
        local_pause.asym && partner_pause.pause && partner_pause.asym |=>
        pause_resolution == 2'h1)
        else $error("transmit-only pause not resolved");
    a_pause_no_sym: assert property (st.complete && !local_pause.pause &&
        !partner_pause.pause |=> pause_resolution == 2'h0)
        else $error("pause resolved without pause ability");
    a_pause_after_done: assert property (negotiation_done ##1
        (local_pause.pause && partner_pause.pause) |=> pause_resolution == 2'h3)
        else $error("pause not resolved after completion");

    // ****************************************************************
    // Scenario coverage
    // ****************************************************************
    c_restart_done: cover property (restart_negotiation ##[1:20] negotiation_done);
    c_strap_capture: cover property ($rose(st.strap_done));
    c_adv_write_read: cover property (wr_adv ##1 rd_adv);
    c_id_read: cover property (rd_id ##1 mgmt_rd_valid);
    c_pause_resolved: cover property (pause_resolution != 2'h0);

endmodule : pidan_regs

`default_nettype wire

// *** verilog/pidan_pkg.sv ***
// Constants, field layout and state record for the PHY identifier and
// auto-negotiation advertisement registers.
// Assumes a management port giving a 5-bit register address, one clock.
//
// Overview of operation
// - ID word bits 15:10 hold identifier bits 19-24
// - ID word bits 9:4 hold fixed model number
// - ID word bits 3:0 hold fixed revision
// - Revision increments for each major silicon change
// - Bit 15 next page request, read-write, reset 0
// - Bit 14 ignores writes, reads zero
// - Bit 13 remote fault advertise, read-write, reset 0
// - Bit 12 reserved, written zero, reads zero
// - Bit 11 asymmetric pause ability, read-write, reset 0
// - Bit 10 symmetric pause ability, read-write, reset 0
// - Resolve pause abilities into two-bit control field
// - Bit 9 four-pair ability fixed zero
// - Bits 8:5 read-write, reset from strap inputs
// - Bits 4:0 selector, read-write, reset 00001
// - Advertisement sent to partner as base page
// - Completion status bit set when negotiation finished
`default_nettype none

package pidan_pkg;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [4:0] ADDR_ID_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADV = 5'h04;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ID_ORG_BITS_LSB = 10;
    localparam int ID_MODEL_LSB = 4;
    localparam int ID_REV_LSB = 0;
    localparam int ADV_NEXT_PAGE = 15;
    localparam int ADV_RSVD_HI = 14;
    localparam int ADV_REMOTE_FAULT = 13;
    localparam int ADV_RSVD_LO = 12;
    localparam int ADV_ASYM_PAUSE = 11;
    localparam int ADV_SYM_PAUSE = 10;
    localparam int ADV_FOUR_PAIR = 9;
    localparam int ADV_ABILITY_LSB = 5;
    localparam int ADV_SELECTOR_LSB = 0;
    localparam int STATUS_COMPLETE_BIT = 5;
    localparam int CTRL_PAUSE_RES_LSB = 12;

    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    localparam logic [15:0] ADV_RESET = 16'h0001;
    localparam logic [15:0] ADV_WRITE_MASK = 16'hadff;
    localparam logic [15:0] ADV_STRAP_MASK = 16'h01e0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] PAUSE_RES_RESET = 2'h0;

    // ****************************************************************
    // State record of the register bank
    // ****************************************************************
    typedef struct packed {
        logic [15:0] adv;
        logic [15:0] rdata;
        logic rd_valid;
        logic strap_done;
        logic start_pending;
        logic complete;
        logic [15:0] base_page;
        logic [1:0] pause_res;
    } pidan_state_s;

    typedef struct packed {
        logic pause;
        logic asym;
    } pidan_pause_s;

endpackage : pidan_pkg

`default_nettype wire

// *** verilog/pidan_pause_res.sv ***
// Pause resolution of local and partner pause abilities.
// Assumes both inputs stable while the result is registered by the caller.
`default_nettype none

module pidan_pause_res (
    input wire pidan_pkg::pidan_pause_s local_ability,
    input wire pidan_pkg::pidan_pause_s partner_ability,
    output logic rx_pause_en,
    output logic tx_pause_en
);

    // ****************************************************************
    // Resolution table
    // ****************************************************************
    always_comb begin
        rx_pause_en = 1'b0;
        tx_pause_en = 1'b0;
        if (local_ability.pause && partner_ability.pause) begin
            rx_pause_en = 1'b1;
            tx_pause_en = 1'b1;
        end else if (local_ability.pause && local_ability.asym &&
                     !partner_ability.pause && partner_ability.asym) begin
            rx_pause_en = 1'b1;
        end else if (!local_ability.pause && local_ability.asym &&
                     partner_ability.pause && partner_ability.asym) begin
            tx_pause_en = 1'b1;
        end
    end

endmodule : pidan_pause_res

`default_nettype wire

// *** test/pidan_mgmt_model.sv ***
// Management controller model for the register port.
// Assumes one calling process; requests launched on rising edges.
`default_nettype none

module pidan_mgmt_model (
    input wire logic clk,
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr_en,
    output logic [15:0] mgmt_wdata,
    output logic mgmt_rd_en,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mgmt_addr = 5'h00;
        mgmt_wr_en = 1'b0;
        mgmt_wdata = 16'h0000;
        mgmt_rd_en = 1'b0;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr_en <= 1'b1;
        @(posedge clk);
        mgmt_wr_en <= 1'b0;
        // Released data shows the inverse
        mgmt_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        mgmt_addr <= a;
        mgmt_rd_en <= 1'b1;
        @(posedge clk);
        mgmt_rd_en <= 1'b0;
        #1;
        d = (mgmt_rd_valid === 1'b1) ? mgmt_rdata : 16'hxxxx;
    endtask : rd

endmodule : pidan_mgmt_model

`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the identifier and advertisement registers.
// Assumes the management model file and the design files are compiled first.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic restart = 1'b0;
    logic done = 1'b0;
    logic [3:0] strap = 4'h0;
    pidan_pkg::pidan_pause_s ppause = '0;
    logic [4:0] mgmt_addr;
    logic mgmt_wr_en;
    logic [15:0] mgmt_wdata;
    logic mgmt_rd_en;
    logic [15:0] mgmt_rdata;
    logic mgmt_rd_valid;
    logic [15:0] base_page_word;
    logic negotiation_complete;
    logic [1:0] pause_resolution;
    logic [31:0] seed = 32'h0001_7910;
    logic [15:0] d;
    logic [15:0] w;
    logic [15:0] rst_val;
    int fails = 0;
    int n_compared = 0;

    always #10 clk = ~clk;

    pidan_mgmt_model mdl_u (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
        .mgmt_wdata(mgmt_wdata), .mgmt_rd_en(mgmt_rd_en), .mgmt_rdata(mgmt_rdata),
        .mgmt_rd_valid(mgmt_rd_valid));

    pidan_regs dut_u (.clk(clk), .arst_n(arst_n), .mgmt_addr(mgmt_addr),
        .mgmt_wr_en(mgmt_wr_en), .mgmt_wdata(mgmt_wdata), .mgmt_rd_en(mgmt_rd_en),
        .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid),
        .strap_abilities(strap), .restart_negotiation(restart),
        .negotiation_done(done), .partner_pause(ppause),
        .base_page_word(base_page_word), .negotiation_complete(negotiation_complete),
        .pause_resolution(pause_resolution));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Operands as {pause, asym}; result {rx, tx}
    function automatic logic [1:0] exp_res(input logic [1:0] l, input logic [1:0] p);
        if (l[1] && p[1]) return 2'h3;
        if (l == 2'h3 && p == 2'h1) return 2'h2;
        if (l == 2'h1 && p == 2'h3) return 2'h1;
        return 2'h0;
    endfunction : exp_res

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #(20 * 5000);
        fails++;
        close_out();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        w = 16'(rnd());
        strap <= w[3:0];
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rst_val = {7'h00, strap, 5'h01};
        mdl_u.rd(5'h04, d);
        chk(d, rst_val);
        chk(base_page_word, rst_val);
        chk({15'h0000, negotiation_complete}, 16'h0000);
        $display("test reset done");
        mdl_u.rd(5'h03, d);
        chk(d, {6'h2a, 6'h15, 4'h3});
        mdl_u.wr(5'h03, 16'(rnd()));
        mdl_u.rd(5'h03, d);
        chk(d, {6'h2a, 6'h15, 4'h3});
        mdl_u.rd(5'h1f, d);
        chk(d, 16'h0000);
        $display("test identifier done");
        for (int i = 0; i < 20; i++) begin
            w = (i == 0) ? 16'hefff : 16'(rnd()) & 16'hefff;
            mdl_u.wr(5'h04, w);
            mdl_u.rd(5'h04, d);
            chk(d, w & 16'hadff);
        end
        $display("test readback done");
        for (int i = 0; i < 16; i++) begin
            w = 16'(rnd()) & 16'hefff;
            w[11] = i[2];
            w[10] = i[3];
            ppause <= pidan_pkg::pidan_pause_s'(i[1:0]);
            mdl_u.wr(5'h04, w);
            @(posedge clk);
            restart <= 1'b1;
            @(posedge clk);
            restart <= 1'b0;
            #1;
            chk(base_page_word, w & 16'hadff);
            chk({15'h0000, negotiation_complete}, 16'h0000);
            @(posedge clk);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            #1;
            chk({15'h0000, negotiation_complete}, 16'h0001);
            @(posedge clk);
            #1;
            chk({14'h0000, pause_resolution}, {14'h0000, exp_res(i[3:2], i[1:0])});
        end
        $display("test negotiation done");
        close_out();
    end

endmodule : tb

`default_nettype wire
